// ### design/pstb_pkg.sv
// constants of the pwm secondary time base and blanking block
// assumes a 100 MHz ref_clk, APB word access, one pwm channel
// Function
// - special_event_irq only while irq enable set; irq follows irq_stat gated by irq_mask
// - period loads immediately or at cycle boundary
// - 4-bit postscaler divides events by N+1
// - high-side edges start blank counter when enabled
// - low-side edges start blank counter when enabled
// - state blank while high-side output high/low
// - state blank while selected signal high/low
// - irq goes to request 73, vector 81
package pstb_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_TB_CTRL = 8'h00;
  localparam logic [7:0] OFF_LEBCON  = 8'h04;
  localparam logic [7:0] OFF_AUXCON  = 8'h08;
  localparam logic [7:0] OFF_PERIOD  = 8'h0c;
  localparam logic [7:0] OFF_ACTPER  = 8'h10;
  localparam logic [7:0] OFF_LEBDLY  = 8'h14;
  localparam logic [7:0] OFF_IRQSTAT = 8'h18;
  localparam logic [7:0] OFF_IRQMASK = 8'h1c;
  // secondary time base control fields
  localparam int STC_PENDING  = 12;
  localparam int STC_IRQ_EN   = 11;
  localparam int STC_IMM_UPD  = 10;
  localparam int STC_PS_LSB   = 0;
  localparam int STC_PS_W     = 4;
  localparam logic [15:0] STC_WMASK = 16'h0c0f;
  // blanking control fields
  localparam int LEB_HR = 15;
  localparam int LEB_HF = 14;
  localparam int LEB_LR = 13;
  localparam int LEB_LF = 12;
  localparam int LEB_FLT_EN = 11;
  localparam int LEB_CL_EN  = 10;
  localparam int LEB_SEL_HI = 5;
  localparam int LEB_SEL_LO = 4;
  localparam int LEB_HS_HI  = 3;
  localparam int LEB_HS_LO  = 2;
  localparam logic [15:0] LEB_WMASK = 16'hfc3c;
  localparam int AUX_SEL_LSB = 0;
  localparam int AUX_SEL_W   = 4;
  // reset values
  localparam logic [15:0] RST_ZERO   = 16'h0000;
  localparam logic [15:0] RST_PERIOD = 16'h00ff;
  localparam logic [15:0] RST_LEBDLY = 16'h0008;
  // interrupt routing
  localparam int IRQ_NUM    = 73;
  localparam int IRQ_VECTOR = 81;
  // interrupt status bits
  localparam int IS_EVENT = 0;
  localparam int IS_BOUND = 1;
  localparam int IS_W     = 2;
endpackage

// ### design/pstb_postscale.sv
// postscaler for special-event triggers
// assumes one-cycle event pulses on ref_clk
`timescale 1ns/1ps
module pstb_postscale (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       reset,
  // control
  input  wire logic [3:0] ratio,
  input  wire logic       event_in,
  // result
  output logic            event_out
);
  logic [3:0] count;

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      count     <= 4'h0;
      event_out <= 1'b0;
    end
    else
    begin
      event_out <= 1'b0;
      if (event_in)
      begin
        if (count >= ratio)
        begin
          count     <= 4'h0;
          event_out <= 1'b1;
        end
        else
          count <= count + 4'h1;
      end
    end
  end

  a_postscale_fire: assert property (@(posedge ref_clk) disable iff (reset)
    event_in && ratio == 4'h0 |=> event_out)
    else $error("ratio zero must pass every event");
endmodule

// ### design/pstb_top.sv
// pwm secondary time base and leading-edge blanking, APB slave
// assumes pwm outputs, fault and current-limit inputs come from pins
`timescale 1ns/1ps
module pstb_top #(
  parameter int NUM_BLANK_SRC = 16
) (
  // clock and reset
  input  wire logic                     ref_clk,
  input  wire logic                     reset,
  // apb slave
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [7:0]               paddr,
  input  wire logic [31:0]              pwdata,
  output logic [31:0]                   prdata,
  output logic                          pready,
  output logic                          pslverr,
  // pwm outputs and blanking sources
  input  wire logic                     high_side_output,
  input  wire logic                     low_side_output,
  input  wire logic [NUM_BLANK_SRC-1:0] blank_sources,
  // protected inputs
  input  wire logic                     fault_in,
  input  wire logic                     current_limit_in,
  output logic                          fault_out,
  output logic                          current_limit_out,
  // interrupt controller side
  output logic                          special_event_irq,
  input  wire logic                     irq_serviced,
  output logic [6:0]                    irq_number,
  output logic [6:0]                    irq_vector,
  output logic                          irq
);
  localparam int IS_W = pstb_pkg::IS_W;
  logic [15:0] tb_ctrl;
  logic [15:0] lebcon;
  logic [15:0] auxcon;
  logic [15:0] period_buf;
  logic [15:0] period_act;
  logic [15:0] leb_delay;
  logic [15:0] tb_count;
  logic [15:0] blank_count;
  logic [IS_W-1:0] irq_stat;
  logic [IS_W-1:0] irq_mask;
  logic        special_event_pending;
  logic        tb_boundary;
  logic        ps_event;
  logic [2:0]  hs_sync;
  logic [2:0]  ls_sync;
  logic [2:0]  flt_sync;
  logic [2:0]  cl_sync;
  logic        hs_q;
  logic        ls_q;
  logic        hs_prev;
  logic        ls_prev;
  logic        leb_start;
  logic        leb_active;
  logic        state_blank;
  logic        sel_level;

  wire logic wr_en = psel && penable && pwrite;
  localparam logic [6:0] IRQ_NUM_C = 7'(pstb_pkg::IRQ_NUM);
  localparam logic [6:0] IRQ_VEC_C = 7'(pstb_pkg::IRQ_VECTOR);

  function automatic logic [15:0] wmerge(input logic [15:0] old, input logic [31:0] d, input logic [15:0] m);
    wmerge = (old & ~m) | (d[15:0] & m);
  endfunction

  // register writes
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      tb_ctrl    <= pstb_pkg::RST_ZERO;
      lebcon     <= pstb_pkg::RST_ZERO;
      auxcon     <= pstb_pkg::RST_ZERO;
      period_buf <= pstb_pkg::RST_PERIOD;
      leb_delay  <= pstb_pkg::RST_LEBDLY;
      irq_mask   <= '0;
    end
    else if (wr_en)
    begin
      if (paddr == pstb_pkg::OFF_TB_CTRL)
        tb_ctrl <= wmerge(tb_ctrl, pwdata, pstb_pkg::STC_WMASK);
      else if (paddr == pstb_pkg::OFF_LEBCON)
        lebcon <= wmerge(lebcon, pwdata, pstb_pkg::LEB_WMASK);
      else if (paddr == pstb_pkg::OFF_AUXCON)
        auxcon <= wmerge(auxcon, pwdata, 16'h000f);
      else if (paddr == pstb_pkg::OFF_PERIOD)
        period_buf <= pwdata[15:0];
      else if (paddr == pstb_pkg::OFF_LEBDLY)
        leb_delay <= pwdata[15:0];
      else if (paddr == pstb_pkg::OFF_IRQMASK)
        irq_mask <= pwdata[IS_W-1:0];
    end
  end

  // secondary time base counter
  assign tb_boundary = (tb_count >= period_act);
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      tb_count <= 16'h0000;
    else if (tb_boundary)
      tb_count <= 16'h0000;
    else
      tb_count <= tb_count + 16'h0001;
  end

  // active period: immediate or at cycle boundary
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      period_act <= pstb_pkg::RST_PERIOD;
    else if (tb_ctrl[pstb_pkg::STC_IMM_UPD] || tb_boundary)
      period_act <= period_buf;
  end

  pstb_postscale u_postscale (
    .ref_clk   (ref_clk),
    .reset     (reset),
    .ratio     (tb_ctrl[pstb_pkg::STC_PS_LSB +: pstb_pkg::STC_PS_W]),
    .event_in  (tb_boundary),
    .event_out (ps_event)
  );

  // pending flag; set wins over service clear
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      special_event_pending <= 1'b0;
    else if (ps_event)
      special_event_pending <= 1'b1;
    else if (irq_serviced)
      special_event_pending <= 1'b0;
  end

  assign special_event_irq = special_event_pending && tb_ctrl[pstb_pkg::STC_IRQ_EN];
  assign irq_number = IRQ_NUM_C;
  assign irq_vector = IRQ_VEC_C;

  // sticky status, write one to clear, set wins
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      irq_stat <= '0;
    else
    begin
      for (int i = 0; i < IS_W; i++)
      begin
        if ((i == pstb_pkg::IS_EVENT && ps_event) || (i == pstb_pkg::IS_BOUND && tb_boundary))
          irq_stat[i] <= 1'b1;
        else if (wr_en && paddr == pstb_pkg::OFF_IRQSTAT && pwdata[i])
          irq_stat[i] <= 1'b0;
      end
    end
  end
  assign irq = |(irq_stat & irq_mask);

  // pin synchronisers; stage 1 only feeds stage 2
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      hs_sync  <= 3'h0;
      ls_sync  <= 3'h0;
      flt_sync <= 3'h0;
      cl_sync  <= 3'h0;
    end
    else
    begin
      hs_sync  <= {hs_sync[1:0], high_side_output};
      ls_sync  <= {ls_sync[1:0], low_side_output};
      flt_sync <= {flt_sync[1:0], fault_in};
      cl_sync  <= {cl_sync[1:0], current_limit_in};
    end
  end

  // filtered level changes once stages 2 and 3 agree
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      hs_q    <= 1'b0;
      ls_q    <= 1'b0;
      hs_prev <= 1'b0;
      ls_prev <= 1'b0;
    end
    else
    begin
      if (hs_sync[1] == hs_sync[2])
        hs_q <= hs_sync[2];
      if (ls_sync[1] == ls_sync[2])
        ls_q <= ls_sync[2];
      hs_prev <= hs_q;
      ls_prev <= ls_q;
    end
  end

  assign leb_start = (lebcon[pstb_pkg::LEB_HR] && hs_q && !hs_prev)
                  || (lebcon[pstb_pkg::LEB_HF] && !hs_q && hs_prev)
                  || (lebcon[pstb_pkg::LEB_LR] && ls_q && !ls_prev)
                  || (lebcon[pstb_pkg::LEB_LF] && !ls_q && ls_prev);

  // leading-edge blanking counter
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      blank_count <= 16'h0000;
    else if (leb_start)
      blank_count <= leb_delay;
    else if (blank_count != 16'h0000)
      blank_count <= blank_count - 16'h0001;
  end
  assign leb_active = (blank_count != 16'h0000);

  // selector beyond the source count reads low
  // compared at 32 bits: a 4-bit cast of 16 would wrap to zero
  assign sel_level = (32'(auxcon[pstb_pkg::AUX_SEL_LSB +: pstb_pkg::AUX_SEL_W]) < NUM_BLANK_SRC)
                   ? blank_sources[auxcon[pstb_pkg::AUX_SEL_LSB +: pstb_pkg::AUX_SEL_W]] : 1'b0;

  assign state_blank = (lebcon[pstb_pkg::LEB_HS_HI] && hs_q)
                    || (lebcon[pstb_pkg::LEB_HS_LO] && !hs_q)
                    || (lebcon[pstb_pkg::LEB_SEL_HI] && sel_level)
                    || (lebcon[pstb_pkg::LEB_SEL_LO] && !sel_level);

  // blanked inputs registered so they stand as data outputs
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      fault_out         <= 1'b0;
      current_limit_out <= 1'b0;
    end
    else
    begin
      fault_out <= flt_sync[2] && !state_blank
                   && !(leb_active && lebcon[pstb_pkg::LEB_FLT_EN]);
      current_limit_out <= cl_sync[2] && !state_blank
                           && !(leb_active && lebcon[pstb_pkg::LEB_CL_EN]);
    end
  end

  // apb read, zero wait state
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
    begin
      if (paddr == pstb_pkg::OFF_TB_CTRL)
        prdata <= {16'h0000, tb_ctrl[15:13], special_event_pending, tb_ctrl[11:0]};
      else if (paddr == pstb_pkg::OFF_LEBCON)
        prdata <= {16'h0000, lebcon};
      else if (paddr == pstb_pkg::OFF_AUXCON)
        prdata <= {16'h0000, auxcon};
      else if (paddr == pstb_pkg::OFF_PERIOD)
        prdata <= {16'h0000, period_buf};
      else if (paddr == pstb_pkg::OFF_ACTPER)
        prdata <= {16'h0000, period_act};
      else if (paddr == pstb_pkg::OFF_LEBDLY)
        prdata <= {16'h0000, leb_delay};
      else if (paddr == pstb_pkg::OFF_IRQSTAT)
        prdata <= {30'h0, irq_stat};
      else if (paddr == pstb_pkg::OFF_IRQMASK)
        prdata <= {30'h0, irq_mask};
      else
        prdata <= 32'h0000_0000;
    end
  end
  assign pready  = 1'b1;
  assign pslverr = 1'b0;

  // assertions
  a_irq_gated: assert property (@(posedge ref_clk) disable iff (reset)
    !tb_ctrl[pstb_pkg::STC_IRQ_EN] |-> !special_event_irq)
    else $error("irq raised while disabled");
  a_period_hold: assert property (@(posedge ref_clk) disable iff (reset)
    !tb_ctrl[pstb_pkg::STC_IMM_UPD] && !tb_boundary |=> $stable(period_act))
    else $error("period changed off boundary");
  a_period_imm: assert property (@(posedge ref_clk) disable iff (reset)
    tb_ctrl[pstb_pkg::STC_IMM_UPD] |=> period_act == $past(period_buf))
    else $error("immediate update missed");
  a_hr_start: assert property (@(posedge ref_clk) disable iff (reset)
    lebcon[pstb_pkg::LEB_HR] && hs_q && !hs_prev |=> blank_count == $past(leb_delay))
    else $error("rising high edge did not start blanking");
  a_lf_start: assert property (@(posedge ref_clk) disable iff (reset)
    lebcon[pstb_pkg::LEB_LF] && !ls_q && ls_prev |=> blank_count == $past(leb_delay))
    else $error("falling low edge did not start blanking");
  a_hs_blank: assert property (@(posedge ref_clk) disable iff (reset)
    lebcon[pstb_pkg::LEB_HS_HI] && hs_q |=> !fault_out && !current_limit_out)
    else $error("inputs not blanked while high side high");
  a_sel_blank: assert property (@(posedge ref_clk) disable iff (reset)
    lebcon[pstb_pkg::LEB_SEL_LO] && !sel_level |=> !fault_out)
    else $error("fault not blanked while selected low");
  a_pend_set: assert property (@(posedge ref_clk) disable iff (reset)
    ps_event |=> special_event_pending ##0 (irq_number == 7'd73 && irq_vector == 7'd81))
    else $error("pending not set or wrong routing");
endmodule

// ### testbench/pstb_top_bench.sv
// self-checking bench for pstb_top: apb register access, postscaled events, blanking
// assumes zero-wait apb slave and synchronous active-high reset
`timescale 1ns/1ps
module pstb_top_bench;
  logic        ref_clk, reset, psel, penable, pwrite, irq_serviced;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, e, m;
  logic        pready, pslverr, hs, ls, fault_in, cl_in, fault_out, cl_out, se_irq, irq;
  logic [15:0] srcs;
  logic [6:0]  irq_number, irq_vector;
  logic [31:0] exp_q[$], msk_q[$];
  int          bad_count, n_tests, lo, n, k;
  realtime     t1;
  pstb_top pstb_top_inst (.ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .high_side_output(hs), .low_side_output(ls), .blank_sources(srcs),
    .fault_in(fault_in), .current_limit_in(cl_in), .fault_out(fault_out),
    .current_limit_out(cl_out), .special_event_irq(se_irq), .irq_serviced(irq_serviced),
    .irq_number(irq_number), .irq_vector(irq_vector), .irq(irq));
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic check_word(input logic [31:0] got, input logic [31:0] want);
    n_tests++;
    if (got !== want)
    begin
      bad_count++;
      $display("ERROR %0t read %h expected %h", $time, got, want);
    end
  endtask
  task automatic check_bit(input logic got, input logic want);
    n_tests++;
    if (got !== want)
    begin
      bad_count++;
      $display("ERROR %0t level %b expected %b", $time, got, want);
    end
  endtask
  // read data is judged by the monitor below, in request order
  always @(posedge ref_clk)
    if (psel && penable && pready === 1'b1 && !pwrite)
    begin
      if (exp_q.size() == 0)
        check_bit(1'b1, 1'b0);
      else
      begin
        e = exp_q.pop_front();
        m = msk_q.pop_front();
        check_word(prdata & m, e & m);
      end
    end
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    i = 0;
    do
    begin
      @(posedge ref_clk);
      i++;
    end
    while (pready !== 1'b1 && i < 50);
    if (i >= 50)
    begin
      bad_count++;
      report_and_stop();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    apb(1'b1, a, {16'h0000, d});
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [31:0] mk);
    exp_q.push_back(x);
    msk_q.push_back(mk);
    apb(1'b0, a, 32'h00000000);
  endtask
  task automatic cyc(input int c);
    repeat (c) @(posedge ref_clk);
  endtask
  // counts cycles in which fault_out is low
  task automatic watch(input int c, output int low);
    low = 0;
    repeat (c)
    begin
      @(posedge ref_clk);
      if (fault_out === 1'b0)
        low++;
    end
  endtask
  task automatic wait_irq();
    n = 0;
    while (se_irq !== 1'b1 && n < 500)
    begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= 500)
    begin
      bad_count++;
      report_and_stop();
    end
  endtask
  task automatic service();
    @(posedge ref_clk);
    irq_serviced <= 1'b1;
    @(posedge ref_clk);
    irq_serviced <= 1'b0;
    @(posedge ref_clk);
  endtask
  initial
  begin
    reset = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
    pwdata = 32'h00000000; hs = 1'b0; ls = 1'b0; srcs = 16'h0000;
    fault_in = 1'b0; cl_in = 1'b0; irq_serviced = 1'b0;
    bad_count = 0; n_tests = 0;
    void'($urandom(64));
    cyc(16);
    reset <= 1'b0;
    fault_in <= 1'b1;
    cl_in <= 1'b1;
    rd(pstb_pkg::OFF_TB_CTRL, 32'h00000000, 32'hffffffff);
    rd(pstb_pkg::OFF_LEBCON, 32'h00000000, 32'hffffffff);
    rd(pstb_pkg::OFF_PERIOD, 32'h000000ff, 32'hffffffff);
    rd(pstb_pkg::OFF_LEBDLY, 32'h00000008, 32'hffffffff);
    rd(8'h20, 32'h00000000, 32'hffffffff);
    check_bit(irq_number === 7'd73 && irq_vector === 7'd81, 1'b1);
    k = $urandom % 16;
    wr(pstb_pkg::OFF_AUXCON, 16'(k));
    rd(pstb_pkg::OFF_AUXCON, 32'(k), 32'hffffffff);
    wr(pstb_pkg::OFF_PERIOD, 16'h0004);
    wr(pstb_pkg::OFF_TB_CTRL, 16'hf3f0);
    rd(pstb_pkg::OFF_TB_CTRL, 32'h00000000, 32'hffffffff);
    watch(1, lo);
    repeat (40)
    begin
      @(posedge ref_clk);
      check_bit(se_irq, 1'b0);
    end
    wr(pstb_pkg::OFF_IRQMASK, 16'h0001);
    // first boundary only comes once the reset period of 255 has run out
    cyc(200);
    check_bit(irq, 1'b1);
    wr(pstb_pkg::OFF_IRQMASK, 16'h0000);
    cyc(1);
    check_bit(irq, 1'b0);
    // ratios 0, 3 and 15: interval between two serviced requests, period 4 gives 5 cycles
    for (int i = 0; i < 3; i++)
    begin
      k = (i == 0) ? 0 : (i == 1) ? 3 : 15;
      wr(pstb_pkg::OFF_TB_CTRL, 16'h0c00 | 16'(k));
      rd(pstb_pkg::OFF_TB_CTRL, 32'h00000c00 | 32'(k), 32'hffffefff);
      wait_irq();
      service();
      wait_irq();
      t1 = $realtime;
      service();
      wait_irq();
      check_word(32'(int'(($realtime - t1) / 10.0)), 32'(5 * (k + 1)));
    end
    wr(pstb_pkg::OFF_PERIOD, 16'h00ff);
    wr(pstb_pkg::OFF_IRQSTAT, 16'h0003);
    rd(pstb_pkg::OFF_IRQSTAT, 32'h00000000, 32'hffffffff);
    rd(pstb_pkg::OFF_ACTPER, 32'h000000ff, 32'hffffffff);
    wr(pstb_pkg::OFF_TB_CTRL, 16'h000f);
    wr(pstb_pkg::OFF_PERIOD, 16'h0010);
    rd(pstb_pkg::OFF_ACTPER, 32'h000000ff, 32'hffffffff);
    cyc(300);
    rd(pstb_pkg::OFF_ACTPER, 32'h00000010, 32'hffffffff);
    // edge triggers: hr, hf, lr, lf; enabled edge blanks 8 cycles, disabled not
    for (int i = 0; i < 4; i++)
    begin
      if (i < 2) hs <= (i == 1); else ls <= (i == 3);
      wr(pstb_pkg::OFF_LEBCON, 16'h0c00 | (16'h8000 >> i));
      cyc(12);
      if (i < 2) hs <= (i == 0); else ls <= (i == 2);
      watch(24, lo);
      check_bit(lo >= 8 && lo <= 10, 1'b1);
      wr(pstb_pkg::OFF_LEBCON, 16'h0c00);
      if (i < 2) hs <= (i == 1); else ls <= (i == 3);
      cyc(12);
      if (i < 2) hs <= (i == 0); else ls <= (i == 2);
      watch(24, lo);
      check_word(32'(lo), 32'h00000000);
    end
    // state blanking: high-side high/low, selected source high/low
    k = $urandom % 16;
    wr(pstb_pkg::OFF_AUXCON, 16'(k));
    for (int j = 0; j < 4; j++)
    begin
      wr(pstb_pkg::OFF_LEBCON, 16'h0001 << (j < 2 ? 3 - j : 7 - j));
      for (int v = 0; v < 2; v++)
      begin
        if (j < 2) hs <= ((j == 0) ^ (v == 1));
        else srcs <= ($urandom & ~(16'h0001 << k)) | (16'(((j == 2) ^ (v == 1))) << k);
        cyc(12);
        check_bit(fault_out, v == 1);
        check_bit(cl_out, v == 1);
      end
    end
    cyc(4);
    report_and_stop();
  end
endmodule
